/* core/dmpp_pkg.sv */
// Package for the drive mode and profile point move control block.
package dmpp_pkg;
    localparam logic [15:0] IDX_CONTROL = 16'h6040;
    localparam logic [15:0] IDX_STATUS = 16'h6041;
    localparam logic [15:0] IDX_MODE_SEL = 16'h6060;
    localparam logic [15:0] IDX_MODE_RB = 16'h6061;
    localparam logic [15:0] IDX_TARGET = 16'h607A;
    localparam logic [15:0] IDX_LIMIT = 16'h607D;
    localparam logic [15:0] IDX_MAX_VEL = 16'h607F;
    localparam logic [15:0] IDX_PROF_VEL = 16'h6081;
    localparam logic [15:0] IDX_PROF_ACC = 16'h6083;
    localparam logic [15:0] IDX_PROF_DEC = 16'h6084;
    localparam logic [15:0] IDX_MAX_ACC = 16'h60C5;
    localparam logic [15:0] IDX_MAX_DEC = 16'h60C6;
    localparam logic [7:0] SUB_0 = 8'h00;
    localparam logic [7:0] SUB_MIN = 8'h01;
    localparam logic [7:0] SUB_MAX = 8'h02;
    localparam logic [7:0] LIMIT_ENTRIES = 8'h02;

    localparam logic [7:0] MODE_NONE = 8'h00;
    localparam logic [7:0] MODE_PROFILE_POINT_MOVE = 8'h01;
    localparam logic [7:0] MODE_ORIGIN_SEARCH = 8'h06;
    localparam logic [7:0] MODE_CYC_POS = 8'h08;
    localparam logic [7:0] MODE_CYC_VEL = 8'h09;

    localparam int CW_QUICK_STOP_BIT = 2;
    localparam int CW_RUN_ENABLE_CMD = 3;
    localparam int CW_NEW_SETPOINT = 4;
    localparam int CW_CHANGE_NOW = 5;
    localparam int CW_RELATIVE = 6;
    localparam int CW_CLEAR_ALARM_EDGE = 7;
    localparam int CW_HALT = 8;
    localparam int SW_WARNING = 7;
    localparam int SW_REMOTE_FLAG = 9;
    localparam int SW_TARGET_REACHED = 10;
    localparam int SW_LIMIT_ACTIVE = 11;
    localparam int SW_SETPOINT_ACK = 12;

    localparam logic [15:0] CW_RESET = 16'h0000;
    localparam logic [31:0] WORD_RESET = 32'h00000000;

    localparam int MODE_SETTLE_US = 2000;
    localparam int CLK_MHZ = 250;
    localparam int MODE_SETTLE_CYC = MODE_SETTLE_US * CLK_MHZ;

    // Power-state flags, status bits 6..0
    typedef struct packed {
        logic switch_on_disabled;
        logic quick_stop_bit;
        logic power_present_flag;
        logic fault;
        logic operation_enabled;
        logic switched_on;
        logic ready_to_switch_on;
    } dmpp_power_t;

    // One move handed to the pulse engine
    typedef struct packed {
        logic [31:0] target;
        logic [31:0] velocity;
        logic [31:0] accel;
        logic [31:0] decel;
    } dmpp_move_t;
endpackage

/* core/dmpp_drive_ctrl.sv */
// Mode selection, software limit and profile point move set-point handling.
`timescale 1ns/1ps
// What this block does
// - Accept mode codes 1, 6, 8, 9
// - Mode select resets to zero, none
// - Read-only read-back shows active mode, reset zero
// - Read-back updates after 2 ms settling
// - Signed limits, count two, disabled if min>=max
// - Clamp velocity, acceleration, deceleration to maxima
// - New set-point rising edge starts move
// - Bit 5 queues or aborts current move
// - Bit 6 selects absolute or relative target
// - Ack bit set by set-point or buffer
// - Target reached on completion or halted stop
// - Status bits 11, 9, 7, 6..0 mapped
// - Quick stop command and status active low
module dmpp_drive_ctrl
    import dmpp_pkg::*;
#(
    parameter int SETTLE_CYCLES = MODE_SETTLE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic obj_req,
    input wire logic obj_write,
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_sub,
    input wire logic [31:0] obj_wdata,
    output logic obj_ack,
    output logic obj_err,
    output logic [31:0] obj_rdata,
    input wire dmpp_power_t power_flags,
    input wire logic warning_in,
    input wire logic remote_flag,
    input wire logic move_done,
    input wire logic axis_stopped,
    input wire logic [31:0] actual_pos,
    output logic quick_stop_req,
    output logic halt_req,
    output logic move_start,
    output dmpp_move_t move_cmd,
    output logic [7:0] active_mode
);
    localparam int TW = $clog2(SETTLE_CYCLES + 1);

    logic [15:0] cw_q;
    logic [7:0] mode_sel_q, mode_act_q, mode_pend_q;
    logic [TW-1:0] settle_q;
    logic [31:0] lim_min_q, lim_max_q, target_q, prof_vel_q, prof_acc_q, prof_dec_q;
    logic [31:0] max_vel_q, max_acc_q, max_dec_q;
    logic nsp_prev_q, busy_q, buf_full_q, buf_rel_q, start_q;
    logic [31:0] buf_target_q, last_target_q;
    dmpp_move_t move_q;
    logic ack_q, err_q;
    logic [31:0] rdata_q;

    function automatic logic mode_ok(input logic [7:0] m);
        return (m == MODE_PROFILE_POINT_MOVE) || (m == MODE_ORIGIN_SEARCH) ||
               (m == MODE_CYC_POS) || (m == MODE_CYC_VEL);
    endfunction

    function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
        return (a > b) ? b : a;
    endfunction

    function automatic logic hit(input logic [15:0] i, input logic [7:0] s,
                                 input logic [15:0] ti, input logic [7:0] ts);
        return (i == ti) && (s == ts);
    endfunction

    wire wr = obj_req && obj_write;
    wire wr_cw = wr && hit(obj_index, obj_sub, IDX_CONTROL, SUB_0);
    wire wr_mode = wr && hit(obj_index, obj_sub, IDX_MODE_SEL, SUB_0);
    wire wr_min = wr && hit(obj_index, obj_sub, IDX_LIMIT, SUB_MIN);
    wire wr_max = wr && hit(obj_index, obj_sub, IDX_LIMIT, SUB_MAX);
    wire mode_take = wr_mode && mode_ok(obj_wdata[7:0]) &&
                     (obj_wdata[7:0] != mode_act_q);

    // Software limit window, off when min >= max
    wire lim_on = $signed(lim_min_q) < $signed(lim_max_q);
    wire lim_active = lim_on && (($signed(actual_pos) < $signed(lim_min_q)) ||
                                 ($signed(actual_pos) > $signed(lim_max_q)));

    wire pp_mode = (mode_act_q == MODE_PROFILE_POINT_MOVE);
    wire nsp_edge = pp_mode && power_flags.operation_enabled &&
                    cw_q[CW_NEW_SETPOINT] && !nsp_prev_q;
    wire done_now = busy_q && move_done;
    // A buffered entry runs before a set-point that arrives as the move ends with bit 5 clear; with bit 5 set the set-point runs and the buffer is dropped
    wire go_direct = nsp_edge &&
                     (!busy_q || (done_now && !buf_full_q) || cw_q[CW_CHANGE_NOW]);
    wire go_queue = nsp_edge && !go_direct;
    wire go_buf = done_now && buf_full_q && !go_direct;
    wire go = go_direct || go_buf;

    // Relative targets add to the previous commanded target
    wire [31:0] base_target = (go_buf ? buf_target_q : target_q);
    wire use_rel = go_buf ? buf_rel_q : cw_q[CW_RELATIVE];
    wire [31:0] raw_target = use_rel ? 32'(last_target_q + base_target) : base_target;
    wire [31:0] lo_cut = ($signed(raw_target) < $signed(lim_min_q)) ? lim_min_q : raw_target;
    wire [31:0] new_target = !lim_on ? raw_target :
                             (($signed(lo_cut) > $signed(lim_max_q)) ? lim_max_q : lo_cut);

    wire sp_ack = cw_q[CW_NEW_SETPOINT] || buf_full_q;
    wire tgt_reached = cw_q[CW_HALT] ? axis_stopped : (!busy_q && !buf_full_q);

    logic [15:0] status_word;
    always_comb begin
        status_word = 16'h0000;
        status_word[$bits(dmpp_power_t)-1:0] = power_flags;
        status_word[SW_WARNING] = warning_in;
        status_word[SW_REMOTE_FLAG] = remote_flag;
        status_word[SW_LIMIT_ACTIVE] = lim_active;
        if (pp_mode) begin
            status_word[SW_TARGET_REACHED] = tgt_reached;
            status_word[SW_SETPOINT_ACK] = sp_ack;
        end
    end

    logic [31:0] rd_mux;
    logic rd_hit, wr_ro;
    always_comb begin
        rd_mux = WORD_RESET;
        rd_hit = 1'b1;
        wr_ro = 1'b0;
        unique case ({obj_index, obj_sub})
            {IDX_CONTROL, SUB_0}: rd_mux = {16'h0000, cw_q};
            {IDX_STATUS, SUB_0}: begin
                rd_mux = {16'h0000, status_word};
                wr_ro = 1'b1;
            end
            {IDX_MODE_SEL, SUB_0}: rd_mux = {{24{mode_sel_q[7]}}, mode_sel_q};
            {IDX_MODE_RB, SUB_0}: begin
                rd_mux = {{24{mode_act_q[7]}}, mode_act_q};
                wr_ro = 1'b1;
            end
            {IDX_LIMIT, SUB_0}: begin
                rd_mux = {24'h000000, LIMIT_ENTRIES};
                wr_ro = 1'b1;
            end
            {IDX_LIMIT, SUB_MIN}: rd_mux = lim_min_q;
            {IDX_LIMIT, SUB_MAX}: rd_mux = lim_max_q;
            {IDX_TARGET, SUB_0}: rd_mux = target_q;
            {IDX_PROF_VEL, SUB_0}: rd_mux = prof_vel_q;
            {IDX_PROF_ACC, SUB_0}: rd_mux = prof_acc_q;
            {IDX_PROF_DEC, SUB_0}: rd_mux = prof_dec_q;
            {IDX_MAX_VEL, SUB_0}: rd_mux = max_vel_q;
            {IDX_MAX_ACC, SUB_0}: rd_mux = max_acc_q;
            {IDX_MAX_DEC, SUB_0}: rd_mux = max_dec_q;
            default: rd_hit = 1'b0;
        endcase
    end

    // Object access answer, one cycle after the request
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= WORD_RESET;
        end else if (clk_en) begin
            ack_q <= obj_req;
            err_q <= obj_req && (!rd_hit || (obj_write && wr_ro));
            if (obj_req && !obj_write) begin
                rdata_q <= rd_hit ? rd_mux : WORD_RESET;
            end
        end
    end

    // Plain writable objects
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cw_q <= CW_RESET;
            lim_min_q <= WORD_RESET;
            lim_max_q <= WORD_RESET;
            target_q <= WORD_RESET;
            prof_vel_q <= WORD_RESET;
            prof_acc_q <= WORD_RESET;
            prof_dec_q <= WORD_RESET;
            max_vel_q <= WORD_RESET;
            max_acc_q <= WORD_RESET;
            max_dec_q <= WORD_RESET;
        end else if (clk_en && wr) begin
            if (wr_cw) cw_q <= obj_wdata[15:0];
            if (wr_min) lim_min_q <= obj_wdata;
            if (wr_max) lim_max_q <= obj_wdata;
            if (hit(obj_index, obj_sub, IDX_TARGET, SUB_0)) target_q <= obj_wdata;
            if (hit(obj_index, obj_sub, IDX_PROF_VEL, SUB_0)) prof_vel_q <= obj_wdata;
            if (hit(obj_index, obj_sub, IDX_PROF_ACC, SUB_0)) prof_acc_q <= obj_wdata;
            if (hit(obj_index, obj_sub, IDX_PROF_DEC, SUB_0)) prof_dec_q <= obj_wdata;
            if (hit(obj_index, obj_sub, IDX_MAX_VEL, SUB_0)) max_vel_q <= obj_wdata;
            if (hit(obj_index, obj_sub, IDX_MAX_ACC, SUB_0)) max_acc_q <= obj_wdata;
            if (hit(obj_index, obj_sub, IDX_MAX_DEC, SUB_0)) max_dec_q <= obj_wdata;
        end
    end

    // Mode select and settling before the read-back follows
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_sel_q <= MODE_NONE;
            mode_act_q <= MODE_NONE;
            mode_pend_q <= MODE_NONE;
            settle_q <= '0;
        end else if (clk_en) begin
            if (wr_mode) begin
                mode_sel_q <= obj_wdata[7:0];
            end
            if (mode_take) begin
                mode_pend_q <= obj_wdata[7:0];
                settle_q <= TW'(SETTLE_CYCLES);
            end else if (settle_q != '0) begin
                settle_q <= settle_q - 1'b1;
                if (settle_q == TW'(1)) mode_act_q <= mode_pend_q;
            end
        end
    end

    // Set-point handshake, one-entry buffer and move issue
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            nsp_prev_q <= 1'b0;
            busy_q <= 1'b0;
            buf_full_q <= 1'b0;
            buf_rel_q <= 1'b0;
            buf_target_q <= WORD_RESET;
            last_target_q <= WORD_RESET;
            start_q <= 1'b0;
            move_q <= '0;
        end else if (clk_en) begin
            nsp_prev_q <= cw_q[CW_NEW_SETPOINT];
            start_q <= go;
            if (go) begin
                busy_q <= 1'b1;
                last_target_q <= new_target;
                move_q.target <= new_target;
                move_q.velocity <= umin(prof_vel_q, max_vel_q);
                move_q.accel <= umin(prof_acc_q, max_acc_q);
                move_q.decel <= umin(prof_dec_q, max_dec_q);
            end else if (done_now || !pp_mode) begin
                busy_q <= 1'b0;
            end
            if (go_queue) begin
                buf_full_q <= 1'b1;
                buf_target_q <= target_q;
                buf_rel_q <= cw_q[CW_RELATIVE];
            end else if (go_buf || (go_direct && cw_q[CW_CHANGE_NOW]) || !pp_mode) begin
                buf_full_q <= 1'b0;
            end
        end
    end

    assign obj_ack = ack_q;
    assign obj_err = err_q;
    assign obj_rdata = rdata_q;
    assign quick_stop_req = !cw_q[CW_QUICK_STOP_BIT];
    assign halt_req = cw_q[CW_HALT];
    assign move_start = start_q;
    assign move_cmd = move_q;
    assign active_mode = mode_act_q;
endmodule

/* sim/dmpp_monitor.sv */
// Assertions on object access, mode settling and move start.
`timescale 1ns/1ps
module dmpp_monitor
    import dmpp_pkg::*;
#(
    parameter int SETTLE_CYCLES = 20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic obj_req,
    input wire logic obj_write,
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_sub,
    input wire logic [31:0] obj_wdata,
    input wire logic obj_ack,
    input wire logic obj_err,
    input wire dmpp_power_t power_flags,
    input wire logic quick_stop_req,
    input wire logic halt_req,
    input wire logic move_start,
    input wire logic [7:0] active_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] cnt_q;
    logic [15:0] cw_q;
    wire take = clk_en && obj_req;
    wire sub0 = obj_sub == SUB_0;
    wire wr_cw = take && obj_write && obj_index == IDX_CONTROL && sub0;
    wire mode_wr = take && obj_write && obj_index == IDX_MODE_SEL && sub0
        && obj_wdata[7:0] inside {8'h01, 8'h06, 8'h08, 8'h09} && obj_wdata[7:0] != active_mode;
    // Cycles since the last accepted mode change
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_q <= 32'h00000000;
            cw_q <= 16'h0000;
        end else if (clk_en) begin
            cnt_q <= mode_wr ? 32'h00000001 : cnt_q + 32'(cnt_q != 32'h00000000);
            cw_q <= wr_cw ? obj_wdata[15:0] : cw_q;
        end
    end
    sequence now_edge_s;
        wr_cw && obj_wdata[4] && !cw_q[4] && obj_wdata[5] && power_flags.operation_enabled
            && active_mode == MODE_PROFILE_POINT_MOVE;
    endsequence
    sequence start_s;
        ##2 move_start;
    endsequence
    ro_write_err_a: assert property (take && obj_write && obj_index == IDX_MODE_RB
        |=> obj_ack && obj_err) else $error("read-back write not refused");
    mode_access_a: assert property (take && obj_index == IDX_MODE_SEL && sub0
        |=> obj_ack && !obj_err) else $error("mode select access refused");
    qs_follow_a: assert property (wr_cw
        |=> quick_stop_req == !$past(obj_wdata[2])) else $error("quick stop level wrong");
    halt_follow_a: assert property (wr_cw
        |=> halt_req == $past(obj_wdata[8])) else $error("halt level wrong");
    mode_legal_a: assert property ($changed(active_mode)
        |-> active_mode inside {8'h01, 8'h06, 8'h08, 8'h09}) else $error("bad active mode");
    mode_settle_a: assert property ($changed(active_mode)
        |-> cnt_q == SETTLE_CYCLES + 1) else $error("mode settle time wrong");
    start_pp_a: assert property (move_start
        |-> active_mode == MODE_PROFILE_POINT_MOVE) else $error("start outside point move");
    start_now_a: assert property (now_edge_s |-> start_s)
        else $error("immediate set-point not started");
endmodule
bind dmpp_drive_ctrl dmpp_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) mon (.core_clk(core_clk),
    .rst_n(rst_n), .clk_en(clk_en), .obj_req(obj_req), .obj_write(obj_write),
    .obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata), .obj_ack(obj_ack),
    .obj_err(obj_err),
    .power_flags(power_flags), .quick_stop_req(quick_stop_req), .halt_req(halt_req),
    .move_start(move_start), .active_mode(active_mode));

/* sim/dmpp_host.sv */
// Host controller model driving the object access port.
`timescale 1ns/1ps
module dmpp_host
    import dmpp_pkg::*;
(
    input wire logic core_clk,
    input wire logic obj_ack,
    input wire logic obj_err,
    input wire logic [31:0] obj_rdata,
    output logic obj_req = 1'b0,
    output logic obj_write = 1'b0,
    output logic [15:0] obj_index = 16'hFFFF,
    output logic [7:0] obj_sub = 8'hFF,
    output logic [31:0] obj_wdata = 32'h00000000
);
    // Released lines show the inverse so stale values are never trusted
    task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d, output logic a, output logic e, output logic [31:0] r);
        @(negedge core_clk);
        {obj_req, obj_write, obj_index, obj_sub, obj_wdata} = {1'b1, w, i, s, d};
        @(negedge core_clk);
        {obj_req, obj_write, obj_index, obj_sub, obj_wdata} = {1'b0, ~w, ~i, ~s, ~d};
        {a, e, r} = {obj_ack, obj_err, obj_rdata};
    endtask
    // Servo-on only after the mode is selected and confirmed
    task automatic servo_on();
        logic [33:0] r;
        access(1'b1, IDX_CONTROL, SUB_0, 32'h06, r[33], r[32], r[31:0]);
        access(1'b1, IDX_CONTROL, SUB_0, 32'h07, r[33], r[32], r[31:0]);
        access(1'b1, IDX_CONTROL, SUB_0, 32'h0F, r[33], r[32], r[31:0]);
    endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the drive control block.
`timescale 1ns/1ps
module testbench;
    import dmpp_pkg::*;
    localparam int ST = 20;
    logic core_clk = 0, rst_n = 0, clk_en = 1, warning_in = 0, remote_flag = 0;
    logic move_done = 0, axis_stopped = 0, obj_req, obj_write, obj_ack, obj_err;
    logic quick_stop_req, halt_req, move_start, a, e;
    logic [15:0] obj_index;
    logic [7:0] obj_sub, active_mode;
    logic [31:0] obj_wdata, obj_rdata, rd, actual_pos = 0;
    dmpp_power_t power_flags = 7'h00;
    dmpp_move_t move_cmd;
    int fails = 0, checks_done = 0;
    dmpp_drive_ctrl #(.SETTLE_CYCLES(ST)) DUT (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(clk_en), .obj_req(obj_req), .obj_write(obj_write), .obj_index(obj_index),
        .obj_sub(obj_sub), .obj_wdata(obj_wdata), .obj_ack(obj_ack), .obj_err(obj_err),
        .obj_rdata(obj_rdata), .power_flags(power_flags), .warning_in(warning_in),
        .remote_flag(remote_flag), .move_done(move_done), .axis_stopped(axis_stopped),
        .actual_pos(actual_pos), .quick_stop_req(quick_stop_req), .halt_req(halt_req),
        .move_start(move_start), .move_cmd(move_cmd), .active_mode(active_mode));
    dmpp_host host (.core_clk(core_clk), .obj_ack(obj_ack), .obj_err(obj_err),
        .obj_rdata(obj_rdata), .obj_req(obj_req), .obj_write(obj_write),
        .obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic check(input string n, input logic [159:0] s, input logic [159:0] x);
        checks_done++;
        if (s !== x) begin
            fails++;
            $display("Error %s expected %0h seen %0h", n, x, s);
        end
    endtask
    task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
        host.access(1'b1, i, s, d, a, e, rd);
    endtask
    task automatic rdc(input string n, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] x);
        host.access(1'b0, i, s, 32'h0, a, e, rd);
        check(n, {a, e, rd}, {2'b10, x});
    endtask
    task automatic errc(input string n, input logic [15:0] i, input logic [7:0] s);
        host.access(1'b1, i, s, 32'h0, a, e, rd);
        check(n, {a, e}, 2'b11);
    endtask
    task automatic st(input string n, input logic [31:0] m, input logic [31:0] x);
        host.access(1'b0, IDX_STATUS, SUB_0, 32'h0, a, e, rd);
        check(n, rd & m, x);
    endtask
    // Completion pulse, then watch a few cycles for a follow-on start
    task automatic fin(input string n, input logic [31:0] t, input logic x);
        logic seen = 0;
        move_done = 1;
        @(negedge core_clk);
        move_done = 0;
        repeat (4) begin
            seen |= move_start && move_cmd.target == t;
            @(negedge core_clk);
        end
        check(n, seen, x);
    endtask
    task automatic t_mode();
        logic [7:0] codes[4] = '{8'h06, 8'h08, 8'h09, 8'h01};
        logic [7:0] prev = 8'h00;
        rdc("mode sel", IDX_MODE_SEL, SUB_0, 32'h0);
        rdc("count", IDX_LIMIT, SUB_0, 32'h2);
        rdc("min", IDX_LIMIT, SUB_MIN, 32'h0);
        errc("ro rb", IDX_MODE_RB, SUB_0);
        errc("ro count", IDX_LIMIT, SUB_0);
        errc("unmapped", 16'h1234, SUB_0);
        foreach (codes[k]) begin
            // Motor is idle while the mode changes
            wr(IDX_MODE_SEL, SUB_0, {24'h0, codes[k]});
            rdc("rb early", IDX_MODE_RB, SUB_0, {24'h0, prev});
            repeat (ST) @(negedge core_clk);
            rdc("rb new", IDX_MODE_RB, SUB_0, {24'h0, codes[k]});
            check("active", active_mode, codes[k]);
            prev = codes[k];
        end
        wr(IDX_MODE_SEL, SUB_0, 32'hFFFFFFFF);
        rdc("sel ext", IDX_MODE_SEL, SUB_0, 32'hFFFFFFFF);
        repeat (ST) @(negedge core_clk);
        rdc("rb kept", IDX_MODE_RB, SUB_0, 32'h1);
        // Settling stalls while the clock enable is low
        wr(IDX_MODE_SEL, SUB_0, 32'h8);
        clk_en = 0;
        repeat (ST) @(negedge core_clk);
        clk_en = 1;
        rdc("rb frozen", IDX_MODE_RB, SUB_0, 32'h1);
        repeat (ST) @(negedge core_clk);
        rdc("rb thawed", IDX_MODE_RB, SUB_0, 32'h8);
        wr(IDX_MODE_SEL, SUB_0, 32'h1);
        repeat (ST) @(negedge core_clk);
        rdc("rb pp", IDX_MODE_RB, SUB_0, 32'h1);
        $display("mode test done");
    endtask
    task automatic t_limit();
        actual_pos = 32'd200;
        st("lim off", 32'h800, 32'h0);
        wr(IDX_LIMIT, SUB_MIN, 32'hFFFFFF9C);
        wr(IDX_LIMIT, SUB_MAX, 32'd100);
        st("lim hi", 32'h800, 32'h800);
        actual_pos = 32'hFFFFFF38;
        st("lim lo", 32'h800, 32'h800);
        wr(IDX_LIMIT, SUB_MIN, 32'd100);
        st("lim eq", 32'h800, 32'h0);
        $display("limit test done");
    endtask
    task automatic t_move();
        {power_flags, warning_in, remote_flag} = {7'h37, 2'b11};
        st("flags", 32'h2FF, 32'h2B7);
        host.servo_on();
        check("qs off", quick_stop_req, 1'b0);
        wr(IDX_CONTROL, SUB_0, 32'h0B);
        check("qs on", quick_stop_req, 1'b1);
        wr(IDX_TARGET, SUB_0, 32'd1000);
        wr(IDX_PROF_VEL, SUB_0, 32'd5000);
        wr(IDX_MAX_VEL, SUB_0, 32'd300);
        wr(IDX_PROF_ACC, SUB_0, 32'd40);
        wr(IDX_MAX_ACC, SUB_0, 32'd70);
        wr(IDX_PROF_DEC, SUB_0, 32'd90);
        wr(IDX_MAX_DEC, SUB_0, 32'd60);
        wr(IDX_CONTROL, SUB_0, 32'h1F);
        @(negedge core_clk);
        check("start", {move_start, move_cmd},
            {1'b1, 32'd1000, 32'd300, 32'd40, 32'd60});
        st("ack busy", 32'h1400, 32'h1000);
        wr(IDX_TARGET, SUB_0, 32'd50);
        wr(IDX_CONTROL, SUB_0, 32'h0F);
        st("ack clr", 32'h1000, 32'h0);
        wr(IDX_CONTROL, SUB_0, 32'h5F);
        wr(IDX_CONTROL, SUB_0, 32'h4F);
        st("ack buf", 32'h1000, 32'h1000);
        fin("queued", 32'd1050, 1'b1);
        wr(IDX_TARGET, SUB_0, 32'd7);
        wr(IDX_CONTROL, SUB_0, 32'h2F);
        wr(IDX_CONTROL, SUB_0, 32'h3F);
        @(negedge core_clk);
        check("abort", {move_start, move_cmd.target}, {1'b1, 32'd7});
        wr(IDX_CONTROL, SUB_0, 32'h0F);
        fin("no queue", 32'd7, 1'b0);
        st("reached", 32'h1400, 32'h0400);
        wr(IDX_CONTROL, SUB_0, 32'h10F);
        check("halt", halt_req, 1'b1);
        st("halt move", 32'h0400, 32'h0);
        axis_stopped = 1;
        st("halt stop", 32'h0400, 32'h0400);
        $display("move test done");
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge core_clk);
        rst_n = 1;
        t_mode();
        t_limit();
        t_move();
        summarize();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        $display("Error watchdog expired");
        summarize();
    end
endmodule
